// file: inc/pll_status_map.svh
`ifndef PLL_STATUS_MAP_SVH
`define PLL_STATUS_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_LOCK_STATUS     14'h3200
`define IDX_OPERATION       14'h3201
`define IDX_STATE           14'h3202
`define IDX_CONTROL         14'h3210
`define IDX_IRQ_STATUS      14'h3211
`define IDX_IRQ_MASK        14'h3212

// Lock status field positions.
`define LOCK_ALL_BIT        0
`define LOCK_PHASE_BIT      1
`define LOCK_FREQ_BIT       2
`define LOCK_ANALOG_BIT     3
`define LOCK_CAL_BUSY_BIT   4
`define LOCK_CAL_DONE_BIT   5

// Operation field positions.
`define OP_FREERUN_BIT      0
`define OP_HOLDOVER_BIT     1
`define OP_REFSW_BIT        2
`define OP_ACTIVE_BIT       3
`define OP_PROF_LSB         4
`define OP_PROF_MSB         6

// State field positions.
`define ST_HISTORY_BIT      0
`define ST_CLAMP_BIT        1
`define ST_SLEW_BIT         2
`define ST_FAST_ACQUISITION_ACT_BIT     4
`define ST_FAST_ACQUISITION_DONE_BIT    5

// Control register: write-only strobes.
`define CTL_UPDATE_BIT      0
`define CTL_FAST_ACQUISITION_CLR_BIT    1

// Interrupt status and mask layout.
`define IRQ_CAL_DONE_BIT    0
`define IRQ_FAST_ACQUISITION_DONE_BIT   1
`define IRQ_LOCK_LOSS_BIT   2

// Reset values.
`define RST_BYTE            8'h00
`define RST_WORD            32'h0000_0000
`define RST_PROF            3'h0
`define RST_IRQ             3'h0

`endif

// file: inc/pll_status_pkg.sv
package pll_status_pkg;

    // Wishbone request from the master.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [15:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    // Indications from the analog and digital loop logic.
    typedef struct packed {
        logic       analog_lock;
        logic       cal_busy;
        logic       cal_start;      // One-cycle pulse when a calibration is issued.
        logic       cal_complete;   // One-cycle pulse when a calibration finishes.
        logic       freq_lock;
        logic       phase_lock;
        logic       active;
        logic [2:0] profile;
        logic       ref_switch;
        logic       holdover;
        logic       freerun;
        logic       fast_acquisition_active;
        logic       fast_acquisition_complete;  // One-cycle pulse when fast acquisition finishes.
        logic       slew_limit;
        logic       freq_clamp;
        logic       history_avail;
    } loop_status_t;

    // Whole state of the readback block.
    typedef struct packed {
        logic        ack;
        logic [31:0] rdat;
        logic        irq;
        logic [2:0]  last_prof;
        logic        cal_done;
        logic        fast_acquisition_done;
        logic [7:0]  op_snap;
        logic [7:0]  st_snap;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic        phase_lock_q;
    } regs_t;

endpackage : pll_status_pkg

// file: hdl/pll_channel_status_readback.sv
// What this block does
// [R1] Lock bit 1 shows digital phase lock.
// [R2] Lock bit 0 is analog AND phase lock.
// [R3] Lock register bits are live, no strobe.
// [R4] Operation bits 6:4 give active profile.
// [R5] Inactive loop keeps last active profile.
// [R6] Operation bit 3 shows reference tracking.
// [R7] Operation bit 2 shows reference switching.
// [R8] Operation bit 1 shows holdover mode.
// [R9] Operation bit 0 shows free-run mode.
// [R10] Operation and state snapshot on update strobe.
// [R11] State bit 5 sticky until cleared.
// [R12] State bit 4 shows fast acquisition active.
// [R13] State bit 2 shows slew limiter active.
// [R14] State bit 1 shows frequency clamp active.
// [R15] State bit 0 shows history available.
// [R16] Lock bits 3,2 show analog, frequency lock.
// [R17] Lock bit 5 calibration done, 4 busy.
// [R18] Reserved bits read zero, ignore writes.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "pll_status_map.svh"

module pll_channel_status_readback (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // Wishbone slave
    input  wire pll_status_pkg::wb_req_t      wb_i,
    output logic                              ack_o,
    output logic [31:0]                       dat_o,
    // Loop indications
    input  wire pll_status_pkg::loop_status_t loop_i,
    // Interrupt
    output logic                              irq_o
);
    import pll_status_pkg::*;

    regs_t       r;
    regs_t       nxt;
    logic        req_new;
    logic        commit_wr;
    logic [13:0] idx;
    logic [7:0]  lock_live;
    logic [2:0]  prof_now;
    logic        upd_stb;
    logic        fast_acquisition_clr;
    logic [2:0]  irq_evt;
    logic [2:0]  irq_w1c;

    // Bus decode: a request is taken when it arrives while ack is low.
    assign idx       = wb_i.adr[15:2];
    assign req_new   = wb_i.cyc && wb_i.stb && !r.ack;
    assign commit_wr = wb_i.cyc && wb_i.stb && wb_i.we && r.ack && wb_i.sel[0];

    // Live lock word, built from the loop inputs and the calibration done flag, with no snapshot.
    always_comb begin
        lock_live = `RST_BYTE;
        lock_live[`LOCK_PHASE_BIT]    = loop_i.phase_lock;                       // R1
        lock_live[`LOCK_ALL_BIT]      = loop_i.analog_lock && loop_i.phase_lock; // R2
        lock_live[`LOCK_ANALOG_BIT]   = loop_i.analog_lock;                      // R16
        lock_live[`LOCK_FREQ_BIT]     = loop_i.freq_lock;                        // R16
        lock_live[`LOCK_CAL_BUSY_BIT] = loop_i.cal_busy;                         // R17
        lock_live[`LOCK_CAL_DONE_BIT] = r.cal_done;                              // R17
    end

    // Profile seen now: the loop's own while active, else the one last used.
    assign prof_now = loop_i.active ? loop_i.profile : r.last_prof; // R5

    // Strobes from the control register take effect on the acked write edge.
    assign upd_stb  = commit_wr && (idx == `IDX_CONTROL) && wb_i.dat[`CTL_UPDATE_BIT];   // R10
    assign fast_acquisition_clr = commit_wr && (idx == `IDX_CONTROL) && wb_i.dat[`CTL_FAST_ACQUISITION_CLR_BIT]; // R11

    // Interrupt events and write-one-to-clear pattern.
    always_comb begin
        irq_evt = `RST_IRQ;
        irq_evt[`IRQ_CAL_DONE_BIT]  = loop_i.cal_complete;
        irq_evt[`IRQ_FAST_ACQUISITION_DONE_BIT] = loop_i.fast_acquisition_complete;
        irq_evt[`IRQ_LOCK_LOSS_BIT] = r.phase_lock_q && !loop_i.phase_lock;
        irq_w1c = `RST_IRQ;
        if (commit_wr && idx == `IDX_IRQ_STATUS) begin
            irq_w1c = wb_i.dat[2:0];
        end
    end

    // Next state of the whole block.
    always_comb begin
        nxt = r;
        nxt.phase_lock_q = loop_i.phase_lock;

        // Single-cycle ack; dropped in the cycle after it was given.
        nxt.ack = req_new;

        // Read data is captured when the request is taken, so the lock word is
        // at most one cycle old when the master sees it.
        if (req_new && !wb_i.we) begin
            case (idx)
                `IDX_LOCK_STATUS: nxt.rdat = {24'h00_0000, lock_live}; // R3
                `IDX_OPERATION:   nxt.rdat = {24'h00_0000, r.op_snap};
                `IDX_STATE:       nxt.rdat = {24'h00_0000, r.st_snap};
                `IDX_IRQ_STATUS:  nxt.rdat = {29'h0000_0000, r.irq_stat};
                `IDX_IRQ_MASK:    nxt.rdat = {29'h0000_0000, r.irq_mask};
                default:          nxt.rdat = `RST_WORD;
            endcase
        end

        // Remember the profile whenever the loop is tracking.
        if (loop_i.active) begin
            nxt.last_prof = loop_i.profile; // R5
        end

        // Calibration done: set on completion, cleared when a new one starts.
        // Completion wins if both arrive together.
        if (loop_i.cal_start) begin
            nxt.cal_done = 1'b0;
        end
        if (loop_i.cal_complete) begin
            nxt.cal_done = 1'b1; // R17
        end

        // Fast acquisition done is sticky; a set beats a simultaneous clear.
        if (fast_acquisition_clr) begin
            nxt.fast_acquisition_done = 1'b0;
        end
        if (loop_i.fast_acquisition_complete) begin
            nxt.fast_acquisition_done = 1'b1; // R11
        end

        // Snapshot of operation and state; reserved bits are forced to zero.
        if (upd_stb) begin
            nxt.op_snap = `RST_BYTE; // R18
            nxt.op_snap[`OP_PROF_MSB:`OP_PROF_LSB] = prof_now; // R4
            nxt.op_snap[`OP_ACTIVE_BIT]   = loop_i.active;      // R6
            nxt.op_snap[`OP_REFSW_BIT]    = loop_i.ref_switch;  // R7
            nxt.op_snap[`OP_HOLDOVER_BIT] = loop_i.holdover;    // R8
            nxt.op_snap[`OP_FREERUN_BIT]  = loop_i.freerun;     // R9
            nxt.st_snap = `RST_BYTE; // R18
            nxt.st_snap[`ST_FAST_ACQUISITION_DONE_BIT] = r.fast_acquisition_done;         // R11
            nxt.st_snap[`ST_FAST_ACQUISITION_ACT_BIT]  = loop_i.fast_acquisition_active;  // R12
            nxt.st_snap[`ST_SLEW_BIT]      = loop_i.slew_limit;   // R13
            nxt.st_snap[`ST_CLAMP_BIT]     = loop_i.freq_clamp;   // R14
            nxt.st_snap[`ST_HISTORY_BIT]   = loop_i.history_avail; // R15
        end

        // Sticky interrupt status: an event in the clearing cycle survives.
        nxt.irq_stat = (r.irq_stat & ~irq_w1c) | irq_evt;
        if (commit_wr && idx == `IDX_IRQ_MASK) begin
            nxt.irq_mask = wb_i.dat[2:0];
        end

        // Registered level interrupt, so the pin comes straight from a flop.
        nxt.irq = |(nxt.irq_stat & nxt.irq_mask);
    end

    // State register; synchronous reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r.ack          <= 1'b0;
            r.rdat         <= `RST_WORD;
            r.irq          <= 1'b0;
            r.last_prof    <= `RST_PROF;
            r.cal_done     <= 1'b0;
            r.fast_acquisition_done    <= 1'b0;
            r.op_snap      <= `RST_BYTE;
            r.st_snap      <= `RST_BYTE;
            r.irq_stat     <= `RST_IRQ;
            r.irq_mask     <= `RST_IRQ;
            r.phase_lock_q <= 1'b0;
        end else begin
            r <= nxt;
        end
    end

    // Outputs straight from the state flops.
    assign ack_o = r.ack;
    assign dat_o = r.rdat;
    assign irq_o = r.irq;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence rd_lock_taken;
        req_new && !wb_i.we && idx == `IDX_LOCK_STATUS;
    endsequence

    sequence rd_op_taken;
        req_new && !wb_i.we && idx == `IDX_OPERATION;
    endsequence

    sequence update_written;
        upd_stb;
    endsequence

    phase_lock_rd_a: assert property (rd_lock_taken |=> // R1
        ack_o && dat_o[`LOCK_PHASE_BIT] == $past(loop_i.phase_lock))
        else $error("Phase lock bit does not match the loop.");

    all_lock_rd_a: assert property (rd_lock_taken |=> // R2
        dat_o[`LOCK_ALL_BIT] == (dat_o[`LOCK_ANALOG_BIT] && dat_o[`LOCK_PHASE_BIT]))
        else $error("All-lock bit is not the AND of analog and phase lock.");

    live_lock_rd_a: assert property (rd_lock_taken |=> // R3
        dat_o[`LOCK_FREQ_BIT] == $past(loop_i.freq_lock)
        && dat_o[`LOCK_CAL_BUSY_BIT] == $past(loop_i.cal_busy))
        else $error("Lock register read is not live.");

    snap_profile_a: assert property (update_written |=> // R4
        r.op_snap[`OP_PROF_MSB:`OP_PROF_LSB] == $past(prof_now))
        else $error("Snapshot profile differs from the profile in use.");

    last_profile_a: assert property (!loop_i.active |=> // R5
        r.last_prof == $past(r.last_prof))
        else $error("Last profile changed while the loop was inactive.");

    snap_mode_a: assert property (update_written |=> // R10
        r.op_snap[3:0] == $past({loop_i.active, loop_i.ref_switch,
                                 loop_i.holdover, loop_i.freerun}))
        else $error("Operation snapshot does not hold the mode bits.");

    snap_hold_a: assert property (!upd_stb ##1 !upd_stb |-> // R10
        $stable(r.op_snap) && $stable(r.st_snap))
        else $error("Snapshot changed without an update strobe.");

    fast_acquisition_sticky_a: assert property (r.fast_acquisition_done && !fast_acquisition_clr |=> r.fast_acquisition_done) // R11
        else $error("Fast acquisition done dropped without a clear.");

    fast_acquisition_set_a: assert property (loop_i.fast_acquisition_complete |=> r.fast_acquisition_done) // R11
        else $error("Fast acquisition done was not set.");

    snap_state_a: assert property (update_written |=> // R12
        r.st_snap[4:0] == $past({loop_i.fast_acquisition_active, 1'b0, loop_i.slew_limit,
                                 loop_i.freq_clamp, loop_i.history_avail}))
        else $error("State snapshot does not hold the loop bits.");

    cal_done_a: assert property (loop_i.cal_complete |=> r.cal_done) // R17
        else $error("Calibration done did not set.");

    cal_clear_a: assert property (loop_i.cal_start && !loop_i.cal_complete |=> // R17
        !r.cal_done)
        else $error("Calibration done did not clear on a new calibration.");

    reserved_op_a: assert property (rd_op_taken |=> dat_o[31:7] == 25'h000_0000) // R18
        else $error("Reserved operation bits read nonzero.");

    irq_level_a: assert property (##1 irq_o == |($past(nxt.irq_stat) & $past(nxt.irq_mask)))
        else $error("Interrupt output disagrees with status and mask.");

    // The checks below tie every snapshot bit outside the profile field to the signal that it
    // mirrors. They are kept one bit to a property so that a failure names the
    // exact field, which saves a trip through the waveform when a bit is swapped.

    // A state register read taken on the bus.
    sequence rd_state_taken;
        req_new && !wb_i.we && idx == `IDX_STATE;
    endsequence

    // The tracking flag is captured by the update strobe.
    op_active_a: assert property (update_written |=> // R6
        r.op_snap[`OP_ACTIVE_BIT] == $past(loop_i.active))
        else $error("Tracking bit not captured at update.");

    // The reference switching flag is captured by the update strobe.
    op_refsw_a: assert property (update_written |=> // R7
        r.op_snap[`OP_REFSW_BIT] == $past(loop_i.ref_switch))
        else $error("Reference switch bit not captured at update.");

    // The holdover flag is captured by the update strobe.
    op_holdover_a: assert property (update_written |=> // R8
        r.op_snap[`OP_HOLDOVER_BIT] == $past(loop_i.holdover))
        else $error("Holdover bit not captured at update.");

    // The free-run flag is captured by the update strobe.
    op_freerun_a: assert property (update_written |=> // R9
        r.op_snap[`OP_FREERUN_BIT] == $past(loop_i.freerun))
        else $error("Free-run bit not captured at update.");

    // The fast acquisition activity flag is captured by the update strobe.
    st_fast_acquisition_act_a: assert property (update_written |=> // R12
        r.st_snap[`ST_FAST_ACQUISITION_ACT_BIT] == $past(loop_i.fast_acquisition_active))
        else $error("Fast acquisition active bit not captured.");

    // The slew limiter flag is captured by the update strobe.
    st_slew_a: assert property (update_written |=> // R13
        r.st_snap[`ST_SLEW_BIT] == $past(loop_i.slew_limit))
        else $error("Slew limiter bit not captured at update.");

    // The frequency clamp flag is captured by the update strobe.
    st_clamp_a: assert property (update_written |=> // R14
        r.st_snap[`ST_CLAMP_BIT] == $past(loop_i.freq_clamp))
        else $error("Frequency clamp bit not captured at update.");

    // The history flag is captured by the update strobe.
    st_history_a: assert property (update_written |=> // R15
        r.st_snap[`ST_HISTORY_BIT] == $past(loop_i.history_avail))
        else $error("History available bit not captured.");

    // The sticky done flag enters the snapshot as it stood before the strobe.
    fast_acquisition_snap_a: assert property (update_written |=> // R11
        r.st_snap[`ST_FAST_ACQUISITION_DONE_BIT] == $past(r.fast_acquisition_done))
        else $error("Fast acquisition done not captured at update.");

    // Analog and frequency lock are read live from the loop inputs.
    lock_levels_a: assert property (rd_lock_taken |=> // R16
        dat_o[`LOCK_ANALOG_BIT] == $past(loop_i.analog_lock)
        && dat_o[`LOCK_FREQ_BIT] == $past(loop_i.freq_lock))
        else $error("Analog or frequency lock bit is wrong.");

    // The calibration done bit reads the flag held in the block.
    lock_cal_rd_a: assert property (rd_lock_taken |=> // R17
        dat_o[`LOCK_CAL_DONE_BIT] == $past(r.cal_done))
        else $error("Calibration done bit reads wrong.");

    // An operation read returns the snapshot, not the live inputs.
    op_read_a: assert property (rd_op_taken |=> // R10
        dat_o[7:0] == $past(r.op_snap))
        else $error("Operation read does not return the snapshot.");

    // A state read returns the snapshot, not the live inputs.
    st_read_a: assert property (rd_state_taken |=> // R10
        dat_o[7:0] == $past(r.st_snap))
        else $error("State read does not return the snapshot.");

    // Reserved state bits, including the hole at bit 3, read as zero.
    reserved_st_a: assert property (rd_state_taken |=> // R18
        dat_o[31:6] == 26'h000_0000 && !dat_o[3])
        else $error("Reserved state bits read nonzero.");

    // The acknowledge is a single pulse, which is what lets the master drop
    // its request on the edge that samples it without a second request being
    // taken by mistake.
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("Acknowledge stood for more than one cycle.");

endmodule : pll_channel_status_readback

// file: tb/pll_channel_status_readback_test.sv
`timescale 1ns/1ps
`include "pll_status_map.svh"

module pll_channel_status_readback_test;
    import pll_status_pkg::*;

    logic         clk_i      = 1'b0;
    logic         rst_i      = 1'b1;
    wb_req_t      wb_i       = '0;
    loop_status_t lp         = '0;
    logic         ack_o;
    logic [31:0]  dat_o;
    logic         irq_o;
    logic [32:0]  exp_q[$];
    logic [32:0]  note;
    int           mismatches = 0;
    int           n_checks   = 0;
    logic [2:0]   last_prof  = 3'h0;
    logic         fast_acquisition_exp   = 1'b0;
    logic         cal_exp    = 1'b0;
    logic [31:0]  op_exp;
    logic [31:0]  st_exp;

    pll_channel_status_readback u_dut (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .wb_i   (wb_i),
        .ack_o  (ack_o),
        .dat_o  (dat_o),
        .loop_i (lp),
        .irq_o  (irq_o)
    );

    // Free-running clock at 10 MHz.
    always #50 clk_i = ~clk_i;

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check

    task automatic summarize;
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // Each acknowledge retires the oldest note; only reads carry a value to compare.
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            if (note[32]) check(dat_o, note[31:0]);
        end
    end

    // One classic cycle; the request is held until ack is sampled high.
    task automatic wb(input logic w, input logic [13:0] idx, input logic [7:0] d,
                      input logic [32:0] e);
        int n;
        n = 0;
        exp_q.push_back(e);
        @(posedge clk_i);
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, sel: 4'hF, dat: {24'h0, d}};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        wb_i.cyc <= 1'b0;
        wb_i.stb <= 1'b0;
    endtask : wb

    task automatic rd(input logic [13:0] idx, input logic [31:0] e);
        wb(1'b0, idx, 8'h00, {1'b1, e});
    endtask : rd

    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, 33'h0);
    endtask : wr

    function automatic logic [31:0] lock_v();
        return {26'h0, cal_exp, lp.cal_busy, lp.analog_lock, lp.freq_lock, lp.phase_lock,
                lp.analog_lock & lp.phase_lock};
    endfunction : lock_v

    function automatic logic [31:0] op_v();
        return {25'h0, last_prof, lp.active, lp.ref_switch, lp.holdover, lp.freerun};
    endfunction : op_v

    function automatic logic [31:0] st_v();
        return {26'h0, fast_acquisition_exp, lp.fast_acquisition_active, 1'b0, lp.slew_limit, lp.freq_clamp,
                lp.history_avail};
    endfunction : st_v

    // New random loop levels; the profile seen while active is remembered.
    task automatic rand_loop;
        loop_status_t t;
        logic [31:0]  r;
        r = $urandom;
        t = lp;
        {t.analog_lock, t.freq_lock, t.phase_lock, t.cal_busy, t.active} = r[4:0];
        t.profile = r[7:5];
        {t.ref_switch, t.holdover, t.freerun, t.fast_acquisition_active} = r[11:8];
        {t.slew_limit, t.freq_clamp, t.history_avail} = r[14:12];
        // The active flag sits in the lowest bit of the draw.
        if (r[0]) last_prof = r[7:5];
        @(posedge clk_i);
        lp <= t;
        repeat (2) @(posedge clk_i);
    endtask : rand_loop

    // One-cycle event pulse: 0 calibration complete, 1 calibration start, 2 fast acq done.
    task automatic pulse(input int which);
        @(posedge clk_i);
        lp.cal_complete  <= (which == 0);
        lp.cal_start     <= (which == 1);
        lp.fast_acquisition_complete <= (which == 2);
        @(posedge clk_i);
        lp.cal_complete  <= 1'b0;
        lp.cal_start     <= 1'b0;
        lp.fast_acquisition_complete <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : pulse

    // Main sequence.
    initial begin
        void'($urandom(32'h8A74));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`IDX_OPERATION, 32'h0);
        rd(`IDX_STATE, 32'h0);
        rd(`IDX_IRQ_MASK, 32'h0);
        rd(`IDX_IRQ_STATUS, 32'h0);
        // Snapshots must hold the values of the update, not the live ones after it.
        for (int i = 0; i < 12; i++) begin
            rand_loop;
            rd(`IDX_LOCK_STATUS, lock_v());
            wr(`IDX_CONTROL, 8'h01);
            op_exp = op_v();
            st_exp = st_v();
            rand_loop;
            rd(`IDX_LOCK_STATUS, lock_v());
            rd(`IDX_OPERATION, op_exp);
            rd(`IDX_STATE, st_exp);
        end
        // Writes to read-only places change nothing; control and unmapped places read zero.
        wr(`IDX_OPERATION, 8'hFF);
        wr(`IDX_STATE, 8'hFF);
        rd(`IDX_OPERATION, op_exp);
        rd(`IDX_CONTROL, 32'h0);
        rd(14'h0100, 32'h0);
        // Calibration done is set by completion and dropped by a new start.
        pulse(0);
        cal_exp = 1'b1;
        rd(`IDX_LOCK_STATUS, lock_v());
        pulse(1);
        cal_exp = 1'b0;
        rd(`IDX_LOCK_STATUS, lock_v());
        // Fast acquisition done stays through updates until cleared.
        pulse(2);
        fast_acquisition_exp = 1'b1;
        wr(`IDX_CONTROL, 8'h01);
        rd(`IDX_STATE, st_v());
        wr(`IDX_CONTROL, 8'h01);
        rd(`IDX_STATE, st_v());
        wr(`IDX_CONTROL, 8'h02);
        fast_acquisition_exp = 1'b0;
        wr(`IDX_CONTROL, 8'h01);
        rd(`IDX_STATE, st_v());
        // Interrupt is raised, masked, unmasked and cleared.
        wr(`IDX_IRQ_STATUS, 8'h07);
        wr(`IDX_IRQ_MASK, 8'h02);
        rd(`IDX_IRQ_STATUS, 32'h0);
        pulse(2);
        repeat (2) @(negedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        rd(`IDX_IRQ_STATUS, 32'h2);
        wr(`IDX_IRQ_MASK, 8'h00);
        repeat (2) @(negedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        wr(`IDX_IRQ_MASK, 8'h02);
        repeat (2) @(negedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        wr(`IDX_IRQ_STATUS, 8'h02);
        repeat (2) @(negedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        rd(`IDX_IRQ_STATUS, 32'h0);
        summarize;
    end

    // Watchdog: the sequence needs well under 2000 cycles, so a long stall is a hang.
    initial begin
        #(100 * 20000);
        mismatches++;
        summarize;
    end

endmodule : pll_channel_status_readback_test
